/* rtl/occ_defines.svh */
// Purpose: Constants for the oscillator and CPU clock control block.
// Assumes: Registers sit on a classic Wishbone bus, one byte per word.
// Notes: Byte address is four times the register index.
//
// Behaviour
// RQ1 - Pin mode register resets to zero, ports.
// RQ2 - Bits 7 and 6 select port, resonator, external.
// RQ3 - Change pin mode only while source halted.
// RQ4 - Divider register resets to 0x01, divide two.
// RQ5 - Divider codes 0..4 give divide 1..16.
// RQ6 - Flash mode pin divides internal fast clock.
// RQ7 - Software writes zero to divider bits 7..3.
// RQ8 - Oscillator mode reads 0x00, then 0x80 stable.
// RQ9 - Stable flag low while settling, high stable.
// RQ10 - Bit 1 halts slow internal oscillator.
// RQ11 - Bit 0 halts fast internal oscillator.
// RQ12 - Halt fast oscillator only when main status one.
// RQ13 - Halt its peripherals before halting fast oscillator.
// RQ14 - Main oscillator control resets to 0x80.
// RQ15 - Halt bit zero runs source, one stops it.
// RQ16 - Halt source only when main status zero.
// RQ17 - Never clear source halt in port mode.
// RQ18 - Reinitialise peripherals after clock restarts.
// RQ19 - Main status zero internal, one high speed; status copies the selector bit, even with the flash pin high.
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// ****************************************************************
// Register indices and reset values
// ****************************************************************
`define OCC_IDX_PIN_MODE 16'hFF9F
`define OCC_IDX_INT_OSC 16'hFFA0
`define OCC_IDX_MAIN_OSC 16'hFFA2
`define OCC_IDX_CPU_DIV 16'hFFFB
`define OCC_IDX_MAIN_SEL 16'hFFA1
`define OCC_RST_PIN_MODE 8'h00
`define OCC_RST_INT_OSC 8'h00
`define OCC_RST_MAIN_OSC 8'h80
`define OCC_RST_CPU_DIV 8'h01
`define OCC_RST_MAIN_SEL 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define OCC_BIT_EXT_SEL 7
`define OCC_BIT_OSC_EN 6
`define OCC_BIT_STABLE 7
`define OCC_BIT_SLOW_HALT 1
`define OCC_BIT_FAST_HALT 0
`define OCC_BIT_SRC_HALT 7
`define OCC_BIT_MAIN_STAT 1
`define OCC_BIT_MAIN_SEL 0

// ****************************************************************
// Timing
// ****************************************************************
`define OCC_CLK_NS 10
`define OCC_SETTLE_NS 1000
`define OCC_SETTLE_CYC (`OCC_SETTLE_NS / `OCC_CLK_NS)

`endif

/* rtl/occ_pkg.sv */
// Purpose: Types for the oscillator and CPU clock control block.
// Assumes: Nothing beyond the defines header.
// Notes: Modes and carried bundles only.
`default_nettype none
package occ_pkg;

    typedef enum logic [1:0] {
        OCC_PIN_PORT,
        OCC_PIN_RESONATOR,
        OCC_PIN_EXTERNAL
    } occ_pin_mode_t;

    typedef struct packed {
        logic fast_osc_run;
        logic slow_osc_run;
        logic resonator_run;
        logic ext_clk_enable;
        logic use_fast_osc;
    } occ_osc_ctrl_t;

    typedef struct packed {
        logic main_clock_status;
        logic fast_osc_stable_flag;
    } occ_status_t;

endpackage
`default_nettype wire

/* rtl/occ_settle.sv */
// Purpose: Settling timer for the internal fast oscillator.
// Assumes: Restarts whenever the oscillator is halted.
// Notes: Done holds high until the oscillator halts again.
`include "occ_defines.svh"
`default_nettype none
module occ_settle #(
    parameter int CYCLES = `OCC_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    output logic done_o
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q, cnt_d;
    logic done_q, done_d;

    // A zero count would never let the stable flag rise.
    if (CYCLES < 1) begin
        $error("occ_settle: CYCLES must be at least one");
    end

    always_comb begin
        cnt_d = cnt_q;
        done_d = done_q;
        if (!run_i) begin
            cnt_d = '0;
            done_d = 1'b0;
        end else if (cnt_q == W'(CYCLES - 1)) begin
            done_d = 1'b1; // RQ9
        end else begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
endmodule
`default_nettype wire

/* rtl/occ_top.sv */
// Purpose: Oscillator and CPU clock control with Wishbone registers.
// Assumes: Classic Wishbone, 8-bit data in low bits of a 32-bit word.
// Notes: One clock; CPU clock is a one-cycle enable from a divider.
//
// Added by the designer: the Wishbone slave port.
`include "occ_defines.svh"
`default_nettype none
module occ_top
    import occ_pkg::*;
#(
    parameter int SETTLE_CYC = `OCC_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Pins and straps
    input wire logic flash_mode_pin_i,
    // Clock control outputs
    output logic cpu_clk_en_o,
    output occ_pin_mode_t pin_mode_o,
    output occ_osc_ctrl_t osc_ctrl_o
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0] pin_mode_q, pin_mode_d;
    logic [7:0] int_osc_q, int_osc_d;
    logic [7:0] main_osc_q, main_osc_d;
    logic [7:0] cpu_div_q, cpu_div_d;
    logic [7:0] main_sel_q, main_sel_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d, err_q, err_d;
    logic stable;
    logic [2:0] flash_sync_q;
    logic flash_q, flash_d;
    logic [3:0] div_cnt_q, div_cnt_d;
    logic cpu_en_q, cpu_en_d;
    occ_pin_mode_t mode_q, mode_d;
    occ_osc_ctrl_t ctrl_q, ctrl_d;
    occ_status_t status;

    function automatic logic [15:0] reg_index(input logic [17:0] adr);
        return adr[17:2];
    endfunction

    function automatic logic [3:0] div_limit(input logic [2:0] code);
        case (code)
            3'h0: return 4'h0;
            3'h1: return 4'h1;
            3'h2: return 4'h3;
            3'h3: return 4'h7;
            3'h4: return 4'hF;
            default: return 4'h1;
        endcase
    endfunction

    if (SETTLE_CYC < 1) begin
        $error("occ_top: SETTLE_CYC must be at least one");
    end

    // ****************************************************************
    // Fast oscillator settling
    // ****************************************************************
    occ_settle #(
        .CYCLES(SETTLE_CYC)
    ) u_settle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(!int_osc_q[`OCC_BIT_FAST_HALT]),
        .done_o(stable)
    );

    assign status.main_clock_status = main_sel_q[`OCC_BIT_MAIN_SEL]; // RQ19
    assign status.fast_osc_stable_flag = stable; // RQ9

    // ****************************************************************
    // Register bus
    // ****************************************************************
    always_comb begin
        logic hit;
        logic req;
        hit = 1'b1;
        req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
        pin_mode_d = pin_mode_q;
        int_osc_d = int_osc_q;
        main_osc_d = main_osc_q;
        cpu_div_d = cpu_div_q;
        main_sel_d = main_sel_q;
        dat_d = dat_q;
        case (reg_index(wb_adr_i))
            `OCC_IDX_PIN_MODE: dat_d = {24'h000000, pin_mode_q};
            `OCC_IDX_INT_OSC: dat_d = {24'h000000, status.fast_osc_stable_flag,
                                       int_osc_q[6:0]}; // RQ8
            `OCC_IDX_MAIN_OSC: dat_d = {24'h000000, main_osc_q};
            `OCC_IDX_CPU_DIV: dat_d = {24'h000000, cpu_div_q};
            `OCC_IDX_MAIN_SEL: dat_d = {24'h000000, 6'h00,
                                        status.main_clock_status,
                                        main_sel_q[0]};
            default: begin
                hit = 1'b0;
                dat_d = 32'h00000000;
            end
        endcase
        if (!req) begin
            dat_d = dat_q;
        end
        if (req && wb_we_i && hit && wb_sel_i[0]) begin
            case (reg_index(wb_adr_i))
                `OCC_IDX_PIN_MODE: pin_mode_d = {wb_dat_i[7:6], 6'h00}; // RQ2
                `OCC_IDX_INT_OSC:
                    int_osc_d = {6'h00, wb_dat_i[1:0]}; // RQ10 RQ11
                `OCC_IDX_MAIN_OSC: main_osc_d = {wb_dat_i[7], 7'h00}; // RQ15
                `OCC_IDX_CPU_DIV: cpu_div_d = {5'h00, wb_dat_i[2:0]}; // RQ5
                `OCC_IDX_MAIN_SEL: main_sel_d = {7'h00, wb_dat_i[0]};
                default: pin_mode_d = pin_mode_q;
            endcase
        end
        ack_d = req && hit;
        err_d = req && !hit;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_mode_q <= `OCC_RST_PIN_MODE; // RQ1
            int_osc_q <= `OCC_RST_INT_OSC; // RQ8
            main_osc_q <= `OCC_RST_MAIN_OSC; // RQ14
            cpu_div_q <= `OCC_RST_CPU_DIV; // RQ4
            main_sel_q <= `OCC_RST_MAIN_SEL;
            dat_q <= 32'h00000000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            pin_mode_q <= pin_mode_d;
            int_osc_q <= int_osc_d;
            main_osc_q <= main_osc_d;
            cpu_div_q <= cpu_div_d;
            main_sel_q <= main_sel_d;
            dat_q <= dat_d;
            ack_q <= ack_d;
            err_q <= err_d;
        end
    end

    // ****************************************************************
    // Flash mode pin synchroniser
    // ****************************************************************
    // The pin changes rarely, so three stages cost nothing and stop glitches.
    always_comb begin
        flash_d = flash_q;
        if (flash_sync_q[1] == flash_sync_q[2]) begin
            flash_d = flash_sync_q[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_sync_q <= 3'h0;
            flash_q <= 1'b0;
        end else begin
            flash_sync_q <= {flash_sync_q[1:0], flash_mode_pin_i};
            flash_q <= flash_d;
        end
    end

    // ****************************************************************
    // Mode decode and CPU clock divider
    // ****************************************************************
    always_comb begin
        mode_d = OCC_PIN_PORT;
        if (pin_mode_q[`OCC_BIT_OSC_EN]) begin
            mode_d = pin_mode_q[`OCC_BIT_EXT_SEL] ? OCC_PIN_EXTERNAL
                                                  : OCC_PIN_RESONATOR; // RQ2
        end
        ctrl_d.fast_osc_run = !int_osc_q[`OCC_BIT_FAST_HALT]; // RQ11
        ctrl_d.slow_osc_run = !int_osc_q[`OCC_BIT_SLOW_HALT]; // RQ10
        ctrl_d.resonator_run = (mode_d == OCC_PIN_RESONATOR) &&
                               !main_osc_q[`OCC_BIT_SRC_HALT]; // RQ15
        ctrl_d.ext_clk_enable = (mode_d == OCC_PIN_EXTERNAL) &&
                                !main_osc_q[`OCC_BIT_SRC_HALT]; // RQ15
        // With the flash pin high the divider always runs from the
        // internal fast clock, whatever the main selector holds.
        ctrl_d.use_fast_osc = flash_q || !main_sel_q[`OCC_BIT_MAIN_SEL]; // RQ6
        // Codes above four are prohibited; they fall back to divide two.
        if (div_cnt_q >= div_limit(cpu_div_q[2:0])) begin
            div_cnt_d = 4'h0;
            cpu_en_d = 1'b1; // RQ5
        end else begin
            div_cnt_d = div_cnt_q + 4'h1;
            cpu_en_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= OCC_PIN_PORT;
            ctrl_q <= '0;
            div_cnt_q <= 4'h0;
            cpu_en_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
            div_cnt_q <= div_cnt_d;
            cpu_en_q <= cpu_en_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign cpu_clk_en_o = cpu_en_q;
    assign pin_mode_o = mode_q;
    assign osc_ctrl_o = ctrl_q;
endmodule
`default_nettype wire

/* verif/occ_top_assertions.sv */
// Purpose: Port assertions for the clock control block.
// Assumes: Bound to occ_top; one clock domain.
// Notes: Bus handshake, reset values and pin mode relations.
`default_nettype none
module occ_top_chk
    import occ_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Clock control outputs
    input var occ_pin_mode_t pin_mode_o,
    input var occ_osc_ctrl_t osc_ctrl_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_ans;
        wb_ack_o ^ wb_err_o;
    endsequence
    chk_bus_answer: assert property (s_req |=> s_ans)
        else $error("request not answered in one cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_no_spurious: assert property (!wb_stb_i |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_port_mode: assert property (pin_mode_o == OCC_PIN_PORT |->
        !osc_ctrl_o.resonator_run && !osc_ctrl_o.ext_clk_enable)
        else $error("source runs in port mode");
    chk_res_mode: assert property (osc_ctrl_o.resonator_run |->
        pin_mode_o == OCC_PIN_RESONATOR)
        else $error("resonator runs outside resonator mode");
    chk_ext_mode: assert property (osc_ctrl_o.ext_clk_enable |->
        pin_mode_o == OCC_PIN_EXTERNAL)
        else $error("external clock outside external mode");
    chk_reset_pins: assert property ($fell(rst_i) |->
        pin_mode_o == OCC_PIN_PORT && !osc_ctrl_o.resonator_run)
        else $error("pins not in port mode after reset");
    chk_reset_oscs: assert property ($fell(rst_i) |=>
        osc_ctrl_o.fast_osc_run && osc_ctrl_o.slow_osc_run)
        else $error("internal oscillators not running after reset");
endmodule
bind occ_top occ_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pin_mode_o(pin_mode_o),
    .osc_ctrl_o(osc_ctrl_o));
`default_nettype wire

/* verif/occ_xsrc.sv */
// Purpose: Behavioural resonator or external clock at the pins.
// Assumes: Runs only while the block enables the source.
// Notes: Rests low while stopped, as a halted crystal does.
`default_nettype none
module occ_xsrc (
    // Control and clock
    input wire logic run_i,
    output logic xclk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial xclk_o = 1'b0;
    always #7 xclk_o = run_i ? ~xclk_o : 1'b0;
endmodule
`default_nettype wire

/* verif/tb_occ_top.sv */
// Purpose: Self-checking bench for the clock control block.
// Assumes: Settling shortened to four cycles.
// Notes: Software order of halts is kept, so no rule is broken.
`default_nettype none
module tb_occ_top import occ_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fpin = 0;
    logic [17:0] adr = '0;
    logic [31:0] wdat = '0, rdat, rd;
    logic ack, err, cen, xclk, gerr;
    occ_pin_mode_t pmode, pexp;
    occ_osc_ctrl_t octl;
    int miscompares = 0, n_checks = 0, npulse = 0, xedges = 0;
    int model[int];
    byte codes[3] = '{8'h01, 8'h03, 8'h02};
    occ_top #(.SETTLE_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .flash_mode_pin_i(fpin), .cpu_clk_en_o(cen),
        .pin_mode_o(pmode), .osc_ctrl_o(octl));
    occ_xsrc u_src (.run_i(octl.resonator_run | octl.ext_clk_enable),
        .xclk_o(xclk));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge xclk) xedges++;
    always @(posedge clk_i) if (cen === 1'b1) npulse++;
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {a, 2'b00};
        wdat <= {24'($urandom), d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!(ack | err) && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("CHECK FAILED %0t: bus hung", $time);
            end_of_test();
        end
        rd = rdat;
        gerr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] m);
        bus(1'b1, a, d);
        model[a] = m;
    endtask
    task automatic rc(input logic [15:0] a);
        bus(1'b0, a, 8'h00);
        chk(rd, 32'(model[a]));
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    initial begin
        void'($urandom(58244));
        model[16'hFF9F] = 8'h00;
        model[16'hFFA0] = 8'h00;
        model[16'hFFA2] = 8'h80;
        model[16'hFFFB] = 8'h01;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(16'hFFA0);
        rc(16'hFF9F);
        rc(16'hFFA2);
        rc(16'hFFFB);
        model[16'hFFA0] = 8'h80;
        rc(16'hFFA0);
        bus(1'b1, 16'hFFA3, 8'($urandom));
        chk(32'(gerr), 32'h1);
        // Source stays halted while the pin mode changes.
        for (int k = 0; k < 4; k++) begin
            wr(16'hFF9F, 8'(k << 6), 8'(k << 6));
            rc(16'hFF9F);
            settle(2);
            pexp = !k[0] ? OCC_PIN_PORT : k[1] ? OCC_PIN_EXTERNAL
                : OCC_PIN_RESONATOR;
            chk(32'(pmode), 32'(pexp));
        end
        wr(16'hFF9F, 8'h40, 8'h40);
        wr(16'hFFA2, 8'h00, 8'h00);
        settle(20);
        chk(32'(octl.resonator_run), 32'h1);
        chk(32'(xedges > 0), 32'h1);
        wr(16'hFFA1, 8'h01, 8'h03);
        rc(16'hFFA1);
        settle(3);
        chk(32'(octl.use_fast_osc), 32'h0);
        fpin <= 1'b1;
        settle(8);
        chk(32'(octl.use_fast_osc), 32'h1);
        fpin <= 1'b0;
        foreach (codes[i]) begin
            wr(16'hFFA0, codes[i], codes[i]);
            rc(16'hFFA0);
            settle(2);
            chk(32'(octl.fast_osc_run), 32'(!codes[i][0]));
            chk(32'(octl.slow_osc_run), 32'(!codes[i][1]));
        end
        wr(16'hFFA0, 8'h00, 8'h80);
        settle(10);
        rc(16'hFFA0);
        wr(16'hFFA1, 8'h00, 8'h00);
        wr(16'hFFA2, 8'h80, 8'h80);
        settle(4);
        xedges = 0;
        settle(20);
        chk(32'(xedges), 32'h0);
        // External clock mode, entered while the source is halted.
        wr(16'hFF9F, 8'hC0, 8'hC0);
        wr(16'hFFA2, 8'h00, 8'h00);
        settle(20);
        chk(32'(octl.ext_clk_enable), 32'h1);
        chk(32'(octl.resonator_run), 32'h0);
        chk(32'(xedges > 0), 32'h1);
        wr(16'hFFA2, 8'h80, 8'h80);
        settle(2);
        chk(32'(octl.ext_clk_enable), 32'h0);
        for (int i = 0; i < 6; i++) begin
            automatic int c = i < 5 ? i : $urandom_range(4, 0);
            wr(16'hFFFB, 8'(c), 8'(c));
            rc(16'hFFFB);
            settle(40);
            npulse = 0;
            settle(160);
            chk(32'(npulse), 32'(160 >> c));
        end
        // A second reset in mid-run must restore every register.
        rst_i <= 1'b1;
        settle(2);
        rst_i <= 1'b0;
        model[16'hFF9F] = 8'h00;
        model[16'hFFA0] = 8'h00;
        model[16'hFFA2] = 8'h80;
        model[16'hFFFB] = 8'h01;
        model[16'hFFA1] = 8'h00;
        rc(16'hFFA0);
        rc(16'hFF9F);
        rc(16'hFFA2);
        rc(16'hFFFB);
        rc(16'hFFA1);
        end_of_test();
    end
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
